// >>> hw/plic_pkg.sv
// package: register map, field layout and state types for the pll lock control block
package plic_pkg;
    // wishbone word offsets (byte addresses)
    localparam logic [3:0] PLIC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] PLIC_ADDR_BANDWIDTH = 4'h4;
    localparam logic [3:0] PLIC_ADDR_STATUS = 4'h8;
    localparam logic [3:0] PLIC_ADDR_MASK = 4'hC;

    // pll_control_reg fields
    localparam int PLIC_CTL_IRQ_ENABLE = 7;
    localparam int PLIC_CTL_IRQ_FLAG = 6;
    localparam int PLIC_CTL_BASE_SEL = 5;
    localparam int PLIC_CTL_POWER = 4;
    // pll_bandwidth_reg fields
    localparam int PLIC_BW_AUTO = 7;
    localparam int PLIC_BW_LOCK = 6;
    // interrupt status and mask fields
    localparam int PLIC_EV_LOCK_CHANGE = 0;
    localparam int PLIC_EV_BITS = 2;
    localparam int PLIC_EV_SEL_CHANGE = 1;

    localparam logic PLIC_POWER_RESET = 1'b1;

    typedef enum logic [1:0] {
        PLIC_RUN = 2'b00,
        PLIC_WAIT = 2'b01,
        PLIC_STOP = 2'b10
    } plic_mode_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } plic_wb_req_s;
endpackage

// >>> hw/plic_top.sv
// pll lock interrupt, base clock interlock and low power mode control
//
// Summary of operation
// - in auto mode with the pll powered and not stopped, every filtered lock edge sets the flag and requests interrupt
// - interrupt enable gates only the request; the flag sets regardless
// - with auto mode off, no pll requests and the flag reads zero
// - base clock may select the vco clock even while unlocked
// - wait mode leaves the clock generator state untouched
// - in wait mode a powered pll still raises lock change interrupts
// - stop mode turns the pll analog section off
// - with break clear enable set, clears in break take effect and stay
// - with break clear enable zero, break accesses leave the flag alone
// - otherwise any read or write of the control register clears the flag
// - lock bit is read only in auto mode and reads zero in manual
// - base select cannot be set while the power bit is clear
// - power bit cannot be cleared while base select stays set; one control write may clear both
`timescale 1ns/1ps
module plic_top
    import plic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire plic_pkg::plic_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic lock_detect_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic break_state_i,
    input wire logic break_clear_enable_i,
    output logic pll_analog_enable_o,
    output logic base_clock_select_o,
    output logic pll_irq_o,
    output logic irq_o
);
    import plic_pkg::*;

    logic lock_s1, lock_s2, lock_s3;
    logic lock_q;
    logic pll_irq_enable, pll_irq_flag, base_clock_select, pll_power_bit, auto_mode;
    logic [PLIC_EV_BITS-1:0] ev_status, ev_mask;
    logic ack_q;
    logic [31:0] rd_data;
    plic_mode_e mode;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    wire bus_go = wb_req_i.cyc && wb_req_i.stb && !ack_q;
    wire wr = bus_go && wb_req_i.we && wb_req_i.sel[0];
    wire rd = bus_go && !wb_req_i.we;
    wire ctl_hit = hit(wb_req_i.adr, PLIC_ADDR_CONTROL);
    wire wr_ctl = wr && ctl_hit;
    wire wr_bw = wr && hit(wb_req_i.adr, PLIC_ADDR_BANDWIDTH);
    wire wr_st = wr && hit(wb_req_i.adr, PLIC_ADDR_STATUS);
    wire wr_mk = wr && hit(wb_req_i.adr, PLIC_ADDR_MASK);
    wire [7:0] wd = wb_req_i.dat[7:0];

    // lock filtered through three stages; change counts when last two agree
    wire lock_stable = (lock_s2 == lock_s3);
    wire lock_now = lock_stable ? lock_s3 : lock_q;
    wire lock_edge = lock_stable && (lock_s3 != lock_q);
    // analog section runs when powered and not stopped; wait does not matter
    wire analog_on = pll_power_bit && (mode != PLIC_STOP);
    wire lock_event = auto_mode && analog_on && lock_edge;
    wire lock_visible = auto_mode && lock_q;
    // break protection: clearing suppressed only when break and bce is zero
    wire clear_allowed = !break_state_i || break_clear_enable_i;
    wire ctl_access = bus_go && ctl_hit && clear_allowed;
    wire next_flag = lock_event ? 1'b1 : (ctl_access ? 1'b0 : pll_irq_flag);
    // set beats clear on the same cycle
    // a write that sets select in the same cycle also keeps the power bit up
    wire next_power = wr_ctl ? (wd[PLIC_CTL_POWER] | next_sel) : pll_power_bit;
    // only the power interlock guards select; lock is not checked
    wire next_sel = wr_ctl ? (wd[PLIC_CTL_BASE_SEL] & pll_power_bit) : base_clock_select;
    wire [PLIC_EV_BITS-1:0] ev_set;
    assign ev_set[PLIC_EV_LOCK_CHANGE] = lock_event;
    assign ev_set[PLIC_EV_SEL_CHANGE] = wr_ctl && (next_sel != base_clock_select);
    wire [PLIC_EV_BITS-1:0] next_status = ev_set | (ev_status & ~(wr_st ? wd[PLIC_EV_BITS-1:0] : '0));

    wire flag_visible = pll_irq_flag && auto_mode;
    wire [7:0] ctl_rd = {pll_irq_enable, flag_visible, base_clock_select, pll_power_bit, 4'h0};
    wire [7:0] bw_rd = {auto_mode, lock_visible, 6'h00};
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (wb_req_i.adr)
            PLIC_ADDR_CONTROL: rd_data[7:0] = ctl_rd;
            PLIC_ADDR_BANDWIDTH: rd_data[7:0] = bw_rd;
            PLIC_ADDR_STATUS: rd_data[PLIC_EV_BITS-1:0] = ev_status;
            PLIC_ADDR_MASK: rd_data[PLIC_EV_BITS-1:0] = ev_mask;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            lock_s3 <= 1'b0;
            lock_q <= 1'b0;
        end
        else if (ce_i)
        begin
            lock_s1 <= lock_detect_i;
            lock_s2 <= lock_s1;
            lock_s3 <= lock_s2;
            lock_q <= lock_now;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pll_irq_enable <= 1'b0;
            pll_irq_flag <= 1'b0;
            base_clock_select <= 1'b0;
            pll_power_bit <= PLIC_POWER_RESET;
            auto_mode <= 1'b0;
            ev_status <= '0;
            ev_mask <= '0;
        end
        else if (ce_i)
        begin
            pll_irq_flag <= next_flag;
            pll_power_bit <= next_power;
            base_clock_select <= next_sel;
            ev_status <= next_status;
            if (wr_ctl)
                pll_irq_enable <= wd[PLIC_CTL_IRQ_ENABLE];
            if (wr_bw)
                auto_mode <= wd[PLIC_BW_AUTO];
            if (wr_mk)
                ev_mask <= wd[PLIC_EV_BITS-1:0];
        end
    end

    // stop has priority over wait; mode only tracks the cpu, clock state is kept
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode <= PLIC_RUN;
        else if (ce_i)
        begin
            case ({stop_mode_i, wait_mode_i})
                2'b00: mode <= PLIC_RUN;
                2'b01: mode <= PLIC_WAIT;
                2'b10, 2'b11: mode <= PLIC_STOP;
                default: mode <= PLIC_RUN;
            endcase
        end
    end

    // one cycle ack, no wait states
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_q <= bus_go;
            if (rd)
                wb_dat_o <= rd_data;
        end
    end

    assign wb_ack_o = ack_q;
    assign pll_analog_enable_o = analog_on;
    assign base_clock_select_o = base_clock_select;
    assign pll_irq_o = flag_visible && pll_irq_enable;
    assign irq_o = |(ev_status & ev_mask);
endmodule

// >>> bench/plic_properties.sv
`timescale 1ns/1ps
// checker for bus timing, clock interlock, low power and interrupt hold
module plic_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire plic_pkg::plic_wb_req_s wb_req_i,
    input wire logic wb_ack_o,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic pll_analog_enable_o,
    input wire logic base_clock_select_o,
    input wire logic pll_irq_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic take = wb_req_i.cyc && wb_req_i.stb && ce_i && !wb_ack_o;
    ack_next_a: assert property (take |=> wb_ack_o) else $error("no ack");
    ack_once_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("long ack");
    sel_power_a: assert property (base_clock_select_o && !$past(stop_mode_i)
        |-> pll_analog_enable_o) else $error("select without pll");
    power_keep_a: assert property ($fell(pll_analog_enable_o)
        |-> $past(stop_mode_i) || !base_clock_select_o) else $error("power cleared");
    stop_off_a: assert property ($past(stop_mode_i) |-> !pll_analog_enable_o) else $error("pll on");
    wait_keep_a: assert property (wait_mode_i && !stop_mode_i && !$past(stop_mode_i)
        && !wb_req_i.cyc |=> $stable(pll_analog_enable_o)) else $error("wait moved pll");
    pll_hold_a: assert property (pll_irq_o && !wb_req_i.cyc |=> pll_irq_o) else $error("irq lost");
    irq_hold_a: assert property (irq_o && !wb_req_i.cyc |=> irq_o) else $error("status lost");
    cover property (take && wb_req_i.we);
    cover property ($rose(pll_irq_o));
    cover property ($fell(pll_analog_enable_o));
endmodule
bind plic_top plic_properties i_plic_properties (.*);

// >>> bench/plic_top_test.sv
`timescale 1ns/1ps
// self-checking bench for the pll lock control block
module plic_top_test;
    logic clk_i = 1'b0, rst_i = 1'b1, lk = 1'b0, wt = 1'b0, sp = 1'b0, bk = 1'b0, bce = 1'b0;
    logic ce = 1'b1;
    logic ack, ana, pirq, irq;
    logic [31:0] dat;
    int n_errors = 0, total_checks = 0;
    plic_pkg::plic_wb_req_s req = '0;
    plic_top i_plic_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req),
        .wb_dat_o(dat), .wb_ack_o(ack), .lock_detect_i(lk), .wait_mode_i(wt),
        .stop_mode_i(sp), .break_state_i(bk), .break_clear_enable_i(bce),
        .pll_analog_enable_o(ana), .base_clock_select_o(), .pll_irq_o(pirq), .irq_o(irq));
    initial forever #25 clk_i = ~clk_i;
    task chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        n_errors += int'(s !== e);
        if (s !== e) $display("Error %0t: got %h exp %h", $time, s, e);
    endtask
    // reads compare the byte against d; the request holds until ack is seen
    task x(input logic [3:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_i) req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
        do @(posedge clk_i); while (ack !== 1'b1);
        if (!w) chk(dat[7:0], d);
        req <= '0;
    endtask
    task stop_test(input int t);
        n_errors += t;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial #200us stop_test(1);
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        x(4'h3, 8'h00, 1'b0);
        x(4'h0, 8'h00, 1'b1);
        x(4'h0, 8'h20, 1'b1);
        x(4'h0, 8'h00, 1'b0);
        x(4'h0, 8'h30, 1'b1);
        x(4'h0, 8'h20, 1'b1);
        x(4'h0, 8'h30, 1'b0);
        $display("interlock test done");
        x(4'h0, 8'h90, 1'b1);
        x(4'h4, 8'h80, 1'b1);
        lk <= 1'b1;
        repeat (8) @(negedge clk_i);
        chk(8'({pirq, irq}), 8'h02);
        x(4'hC, 8'h01, 1'b1);
        x(4'h4, 8'hC0, 1'b0);
        x(4'h0, 8'h10, 1'b1);
        lk <= 1'b0;
        repeat (8) @(negedge clk_i);
        chk(8'({pirq, irq}), 8'h01);
        x(4'h0, 8'h50, 1'b0);
        $display("interrupt test done");
        x(4'h0, 8'h90, 1'b1);
        lk <= 1'b1;
        repeat (8) @(posedge clk_i);
        bk <= 1'b1;
        x(4'h0, 8'hD0, 1'b0);
        bce <= 1'b1;
        x(4'h0, 8'hD0, 1'b0);
        bk <= 1'b0;
        x(4'h0, 8'h90, 1'b0);
        wt <= 1'b1;
        lk <= 1'b0;
        repeat (8) @(negedge clk_i);
        chk(8'({pirq, ana}), 8'h03);
        x(4'h4, 8'h00, 1'b1);
        x(4'h0, 8'h90, 1'b0);
        x(4'h0, 8'h10, 1'b1);
        sp <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk(8'(ana), 8'h00);
        @(posedge clk_i);
        sp <= 1'b0;
        wt <= 1'b0;
        x(4'h4, 8'h80, 1'b1);
        x(4'h0, 8'h90, 1'b1);
        // frozen clock enable must hide the lock change until it returns
        ce <= 1'b0;
        lk <= 1'b1;
        repeat (8) @(negedge clk_i);
        chk(8'(pirq), 8'h00);
        @(posedge clk_i);
        ce <= 1'b1;
        repeat (8) @(negedge clk_i);
        chk(8'(pirq), 8'h01);
        x(4'h4, 8'hC0, 1'b0);
        x(4'h0, 8'hB0, 1'b1);
        x(4'h0, 8'hB0, 1'b0);
        $display("low power test done");
        stop_test(0);
    end
endmodule
